/* File: hdl/amsm_params.svh */
// Register map, field positions and timing constants of the axis motion state machine
// Operation
// - Absolute move accepted in standstill, discrete or continuous; drives to commanded position.
// - Relative move target equals distance plus actual position sampled at execution.
// - Velocity move runs endlessly at commanded velocity until replaced; same valid states.
// - Homing accepted only in standstill; loads position after reference and offset.
// - Successful homing returns to standstill and reports done.
// - Stop accepted in standstill, motion or homing; aborts others, enters stopping.
// - While stopping, every other motion command is refused.
// - Stop done rises when axis velocity reaches zero.
// - Axis stays stopping while stop execute high or velocity nonzero.
// - Stopping goes to standstill once stop done and execute low.
// - Halt accepted in standstill or motion; decelerates holding discrete motion.
// - Halt done moves the axis to standstill.
// - A second power command instance seizing an owned axis forces error stop.
// - Disabling power de-powers the axis; issuer disables before reconfiguring.
// - With ready monitoring on, motion commands other than stop are refused until drive ready.
// - In-position not seen within five seconds after the last pulse of an absolute or relative move flags mechanical error.
// - Move parameters are captured only on execute rising edge; home offset and home position are read when used.
`ifndef AMSM_PARAMS_SVH
`define AMSM_PARAMS_SVH

`define AMSM_ADDR_CTRL 8'h00
`define AMSM_ADDR_EXEC 8'h04
`define AMSM_ADDR_POS 8'h08
`define AMSM_ADDR_VEL 8'h0C
`define AMSM_ADDR_HOMEPOS 8'h10
`define AMSM_ADDR_HOMEOFS 8'h14
`define AMSM_ADDR_STATUS 8'h18
`define AMSM_ADDR_ACTPOS 8'h1C
`define AMSM_ADDR_IRQST 8'h20
`define AMSM_ADDR_IRQMASK 8'h24

`define AMSM_CTRL_PWR 0
`define AMSM_CTRL_ID_LSB 4
`define AMSM_CTRL_ID_MSB 7
`define AMSM_CTRL_RDYMON 8
`define AMSM_CTRL_INPOS 9
`define AMSM_VEL_NEG 16

`define AMSM_CMD_ABS 0
`define AMSM_CMD_REL 1
`define AMSM_CMD_VEL 2
`define AMSM_CMD_HOME 3
`define AMSM_CMD_STOP 4
`define AMSM_CMD_HALT 5

`define AMSM_STAT_MECH 3
`define AMSM_STAT_DONE_LSB 8
`define AMSM_STAT_ERR_LSB 16
`define AMSM_STAT_READY 24
`define AMSM_STAT_INPOS 25

`define AMSM_IRQ_DONE 0
`define AMSM_IRQ_REJECT 1
`define AMSM_IRQ_MECH 2
`define AMSM_IRQ_ERRSTOP 3

`define AMSM_RAMP_STEP 16'h0010
`define AMSM_CLK_MHZ 250
`define AMSM_INPOS_TIMEOUT_MS 5000

`endif

/* File: hdl/amsm_pkg.sv */
// Types of the axis motion state machine
package amsm_pkg;

    typedef enum logic [2:0] {
        ST_DISABLED,
        ST_STANDSTILL,
        ST_DISCRETE,
        ST_CONTINUOUS,
        ST_HOMING,
        ST_STOPPING,
        ST_ERRORSTOP
    } amsm_state_e;

    typedef struct packed {
        amsm_state_e state;
        logic homeSeek;
        logic fresh;
        logic [2:0] activeCmd;
        logic [5:0] exec;
        logic [5:0] execPrev;
        logic [5:0] done;
        logic [5:0] err;
        logic powerEn;
        logic [3:0] ownerId;
        logic readyMonEn;
        logic inPosEn;
        logic [31:0] posParam;
        logic [15:0] velParam;
        logic velNeg;
        logic [31:0] homePos;
        logic [31:0] homeOffset;
        logic [31:0] tgtPos;
        logic [15:0] cmdVel;
        logic posMode;
        logic dirNeg;
        logic run;
        logic loadPos;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic inPosArm;
        logic mechErr;
        logic [31:0] inPosCnt;
        logic [3:0] irqSt;
        logic [3:0] irqMask;
        logic irq;
        logic [31:0] rdData;
    } amsm_ctrl_s;

    typedef struct packed {
        logic [15:0] acc;
        logic [15:0] curVel;
        logic [31:0] pos;
        logic dir;
        logic pulse;
        logic velZero;
        logic atTarget;
    } amsm_gen_s;

endpackage

/* File: hdl/amsm_motion_if.sv */
// Link between the axis sequencer and its step generator
`timescale 1ns/1ps
interface amsm_motion_if;
    logic [31:0] tgtPos;
    logic [15:0] cmdVel;
    logic posMode;
    logic dirNeg;
    logic run;
    logic loadPos;
    logic [31:0] loadVal;
    logic [31:0] actPos;
    logic velZero;
    logic atTarget;
    logic stepPulse;
    logic stepDir;

    modport ctl (
        output tgtPos, cmdVel, posMode, dirNeg, run, loadPos, loadVal,
        input actPos, velZero, atTarget, stepPulse, stepDir
    );
    modport gen (
        input tgtPos, cmdVel, posMode, dirNeg, run, loadPos, loadVal,
        output actPos, velZero, atTarget, stepPulse, stepDir
    );
endinterface

/* File: hdl/amsm_step_gen.sv */
// Step and direction generator with linear velocity ramp
`timescale 1ns/1ps
`include "amsm_params.svh"
module amsm_step_gen #(
    parameter logic [15:0] RAMP_STEP = `AMSM_RAMP_STEP
) (
    input wire logic core_clk,
    input wire logic nrst,
    amsm_motion_if.gen mi
);
    amsm_pkg::amsm_gen_s gen_r;
    amsm_pkg::amsm_gen_s gen_nxt;
    logic desDir;
    logic [15:0] desVel;
    logic carry;
    logic step;
    logic atTgt;

    always_comb
    begin
        gen_nxt = gen_r;
        atTgt = mi.posMode && (gen_r.pos == mi.tgtPos);
        desDir = mi.posMode ? ($signed(mi.tgtPos) < $signed(gen_r.pos)) : mi.dirNeg;
        desVel = (!mi.run || atTgt) ? 16'h0000 : mi.cmdVel;
        // Reversal only through zero velocity
        if (gen_r.curVel == 16'h0000)
        begin
            gen_nxt.dir = desDir;
        end
        else if (gen_r.dir != desDir)
        begin
            desVel = 16'h0000;
        end
        if (gen_r.curVel < desVel)
        begin
            gen_nxt.curVel = ((desVel - gen_r.curVel) > RAMP_STEP) ? gen_r.curVel + RAMP_STEP : desVel;
        end
        else
        begin
            gen_nxt.curVel = ((gen_r.curVel - desVel) > RAMP_STEP) ? gen_r.curVel - RAMP_STEP : desVel;
        end
        // No decel planning: a position move stops hard on its last pulse
        if (atTgt)
        begin
            gen_nxt.curVel = 16'h0000;
        end
        {carry, gen_nxt.acc} = {1'b0, gen_r.acc} + {1'b0, gen_r.curVel};
        step = carry && !atTgt;
        gen_nxt.pulse = step;
        if (step)
        begin
            gen_nxt.pos = gen_r.dir ? gen_r.pos - 32'h0000_0001 : gen_r.pos + 32'h0000_0001;
        end
        if (mi.loadPos)
        begin
            gen_nxt.pos = mi.loadVal;
        end
        gen_nxt.velZero = (gen_nxt.curVel == 16'h0000);
        gen_nxt.atTarget = (gen_nxt.pos == mi.tgtPos);
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gen_r <= '0;
        end
        else
        begin
            gen_r <= gen_nxt;
        end
    end

    assign mi.actPos = gen_r.pos;
    assign mi.velZero = gen_r.velZero;
    assign mi.atTarget = gen_r.atTarget;
    assign mi.stepPulse = gen_r.pulse;
    assign mi.stepDir = gen_r.dir;
endmodule

/* File: hdl/amsm_axis_ctrl.sv */
// Axis command sequencer with register port, interrupt and drive pins
`timescale 1ns/1ps
`include "amsm_params.svh"
module amsm_axis_ctrl #(
    parameter logic [31:0] INPOS_CYCLES = 32'(`AMSM_INPOS_TIMEOUT_MS * `AMSM_CLK_MHZ * 1000)
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic driveReady,
    input wire logic inPosition,
    input wire logic homeRef,
    output logic stepPulse,
    output logic stepDir,
    output logic driveOn,
    output logic irq
);
    amsm_pkg::amsm_ctrl_s ax_r;
    amsm_pkg::amsm_ctrl_s ax_nxt;
    amsm_motion_if mi ();

    logic [5:0] rise;
    logic ready;
    logic moveOk;
    logic stopOk;
    logic [31:0] relSum;
    logic [3:0] evt;
    logic [3:0] irqClr;
    logic ctrlClash;

    amsm_step_gen u_gen (
        .core_clk(core_clk),
        .nrst(nrst),
        .mi(mi)
    );

    assign rise = ax_r.exec & ~ax_r.execPrev;
    assign ready = !ax_r.readyMonEn || ax_r.sync2[0];
    assign moveOk = ready && (ax_r.state inside {amsm_pkg::ST_STANDSTILL, amsm_pkg::ST_DISCRETE,
        amsm_pkg::ST_CONTINUOUS});
    assign stopOk = ax_r.state inside {amsm_pkg::ST_STANDSTILL, amsm_pkg::ST_DISCRETE,
        amsm_pkg::ST_CONTINUOUS, amsm_pkg::ST_HOMING};
    assign relSum = mi.actPos + ax_r.posParam;
    assign irqClr = (regWr && regAddr == `AMSM_ADDR_IRQST) ? regWdata[3:0] : 4'h0;
    assign ctrlClash = regWr && regAddr == `AMSM_ADDR_CTRL && regWdata[`AMSM_CTRL_PWR] && ax_r.powerEn
        && regWdata[`AMSM_CTRL_ID_MSB:`AMSM_CTRL_ID_LSB] != ax_r.ownerId;

    always_comb
    begin
        ax_nxt = ax_r;
        evt = 4'h0;
        ax_nxt.sync1 = {homeRef, inPosition, driveReady};
        ax_nxt.sync2 = ax_r.sync1;
        ax_nxt.execPrev = ax_r.exec;
        ax_nxt.loadPos = 1'b0;
        ax_nxt.fresh = 1'b0;
        ax_nxt.done = ax_r.done & ~rise;
        ax_nxt.err = ax_r.err & ~rise;

        if (ax_r.inPosArm)
        begin
            if (ax_r.sync2[1])
            begin
                ax_nxt.inPosArm = 1'b0;
            end
            else if (ax_r.inPosCnt >= INPOS_CYCLES - 32'h0000_0001)
            begin
                ax_nxt.inPosArm = 1'b0;
                ax_nxt.mechErr = 1'b1;
                evt[`AMSM_IRQ_MECH] = 1'b1;
            end
            else
            begin
                ax_nxt.inPosCnt = ax_r.inPosCnt + 32'h0000_0001;
            end
        end

        // Stop outranks every other command seen in the same cycle
        if (rise[`AMSM_CMD_STOP])
        begin
            if (stopOk)
            begin
                ax_nxt.state = amsm_pkg::ST_STOPPING;
                ax_nxt.run = 1'b0;
                ax_nxt.activeCmd = 3'(`AMSM_CMD_STOP);
                ax_nxt.inPosArm = 1'b0;
            end
            else
            begin
                ax_nxt.err[`AMSM_CMD_STOP] = 1'b1;
                evt[`AMSM_IRQ_REJECT] = 1'b1;
            end
        end
        else if (rise[`AMSM_CMD_HALT])
        begin
            if (moveOk)
            begin
                ax_nxt.state = amsm_pkg::ST_DISCRETE;
                ax_nxt.run = 1'b0;
                ax_nxt.activeCmd = 3'(`AMSM_CMD_HALT);
                ax_nxt.fresh = 1'b1;
            end
            else
            begin
                ax_nxt.err[`AMSM_CMD_HALT] = 1'b1;
                evt[`AMSM_IRQ_REJECT] = 1'b1;
            end
        end
        else if (rise[`AMSM_CMD_HOME])
        begin
            if (ready && ax_r.state == amsm_pkg::ST_STANDSTILL)
            begin
                ax_nxt.state = amsm_pkg::ST_HOMING;
                ax_nxt.homeSeek = 1'b1;
                ax_nxt.posMode = 1'b0;
                ax_nxt.dirNeg = 1'b1;
                ax_nxt.cmdVel = ax_r.velParam;
                ax_nxt.run = 1'b1;
                ax_nxt.activeCmd = 3'(`AMSM_CMD_HOME);
            end
            else
            begin
                ax_nxt.err[`AMSM_CMD_HOME] = 1'b1;
                evt[`AMSM_IRQ_REJECT] = 1'b1;
            end
        end
        else if (rise[`AMSM_CMD_VEL])
        begin
            if (moveOk)
            begin
                ax_nxt.state = amsm_pkg::ST_CONTINUOUS;
                ax_nxt.posMode = 1'b0;
                ax_nxt.dirNeg = ax_r.velNeg;
                ax_nxt.cmdVel = ax_r.velParam;
                ax_nxt.run = 1'b1;
                ax_nxt.activeCmd = 3'(`AMSM_CMD_VEL);
                ax_nxt.inPosArm = 1'b0;
            end
            else
            begin
                ax_nxt.err[`AMSM_CMD_VEL] = 1'b1;
                evt[`AMSM_IRQ_REJECT] = 1'b1;
            end
        end
        else if (rise[`AMSM_CMD_REL] || rise[`AMSM_CMD_ABS])
        begin
            if (moveOk)
            begin
                ax_nxt.state = amsm_pkg::ST_DISCRETE;
                ax_nxt.tgtPos = rise[`AMSM_CMD_REL] ? relSum : ax_r.posParam;
                ax_nxt.posMode = 1'b1;
                ax_nxt.cmdVel = ax_r.velParam;
                ax_nxt.run = 1'b1;
                ax_nxt.activeCmd = rise[`AMSM_CMD_REL] ? 3'(`AMSM_CMD_REL) : 3'(`AMSM_CMD_ABS);
                ax_nxt.fresh = 1'b1;
                ax_nxt.inPosArm = 1'b0;
            end
            else
            begin
                ax_nxt.err = ax_nxt.err | (rise & 6'h03);
                evt[`AMSM_IRQ_REJECT] = 1'b1;
            end
        end
        else if (!ax_r.fresh)
        begin
            case (ax_r.state)
                amsm_pkg::ST_STOPPING:
                begin
                    if (mi.velZero && !ax_r.done[`AMSM_CMD_STOP])
                    begin
                        ax_nxt.done[`AMSM_CMD_STOP] = 1'b1;
                        evt[`AMSM_IRQ_DONE] = 1'b1;
                    end
                end
                amsm_pkg::ST_DISCRETE:
                begin
                    if (mi.velZero && (ax_r.activeCmd == 3'(`AMSM_CMD_HALT) || mi.atTarget))
                    begin
                        ax_nxt.state = amsm_pkg::ST_STANDSTILL;
                        ax_nxt.done[ax_r.activeCmd] = 1'b1;
                        ax_nxt.run = 1'b0;
                        evt[`AMSM_IRQ_DONE] = 1'b1;
                        if (ax_r.activeCmd != 3'(`AMSM_CMD_HALT) && ax_r.inPosEn)
                        begin
                            ax_nxt.inPosArm = 1'b1;
                            ax_nxt.inPosCnt = 32'h0000_0000;
                        end
                    end
                end
                amsm_pkg::ST_HOMING:
                begin
                    if (ax_r.homeSeek)
                    begin
                        if (ax_r.sync2[2])
                        begin
                            ax_nxt.homeSeek = 1'b0;
                            ax_nxt.tgtPos = mi.actPos + ax_r.homeOffset;
                            ax_nxt.posMode = 1'b1;
                            ax_nxt.fresh = 1'b1;
                        end
                    end
                    else if (mi.velZero && mi.atTarget)
                    begin
                        ax_nxt.loadPos = 1'b1;
                        ax_nxt.state = amsm_pkg::ST_STANDSTILL;
                        ax_nxt.done[`AMSM_CMD_HOME] = 1'b1;
                        ax_nxt.run = 1'b0;
                        evt[`AMSM_IRQ_DONE] = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Release is not held off by a refused command in the same cycle
        if (ax_r.state == amsm_pkg::ST_STOPPING && ax_r.done[`AMSM_CMD_STOP] && !ax_r.exec[`AMSM_CMD_STOP])
        begin
            ax_nxt.state = amsm_pkg::ST_STANDSTILL;
        end

        if (regWr)
        begin
            case (regAddr)
                `AMSM_ADDR_CTRL:
                begin
                    if (ctrlClash)
                    begin
                        ax_nxt.state = amsm_pkg::ST_ERRORSTOP;
                        evt[`AMSM_IRQ_ERRSTOP] = 1'b1;
                    end
                    else
                    begin
                        ax_nxt.powerEn = regWdata[`AMSM_CTRL_PWR];
                        ax_nxt.ownerId = regWdata[`AMSM_CTRL_ID_MSB:`AMSM_CTRL_ID_LSB];
                    end
                    ax_nxt.readyMonEn = regWdata[`AMSM_CTRL_RDYMON];
                    ax_nxt.inPosEn = regWdata[`AMSM_CTRL_INPOS];
                    // A timeout in the same cycle wins over the clear
                    ax_nxt.mechErr = evt[`AMSM_IRQ_MECH];
                end
                `AMSM_ADDR_EXEC:
                    ax_nxt.exec = regWdata[5:0];
                `AMSM_ADDR_POS:
                    ax_nxt.posParam = regWdata;
                `AMSM_ADDR_VEL:
                begin
                    ax_nxt.velParam = regWdata[15:0];
                    ax_nxt.velNeg = regWdata[`AMSM_VEL_NEG];
                end
                `AMSM_ADDR_HOMEPOS:
                    ax_nxt.homePos = regWdata;
                `AMSM_ADDR_HOMEOFS:
                    ax_nxt.homeOffset = regWdata;
                `AMSM_ADDR_IRQMASK:
                    ax_nxt.irqMask = regWdata[3:0];
                default:
                begin
                end
            endcase
        end

        if (ax_nxt.state == amsm_pkg::ST_ERRORSTOP)
        begin
            ax_nxt.run = 1'b0;
        end
        if (!ax_nxt.powerEn)
        begin
            ax_nxt.state = amsm_pkg::ST_DISABLED;
            ax_nxt.run = 1'b0;
        end
        else if (ax_r.state == amsm_pkg::ST_DISABLED)
        begin
            ax_nxt.state = amsm_pkg::ST_STANDSTILL;
        end

        // New events win over a same-cycle clear
        ax_nxt.irqSt = (ax_r.irqSt & ~irqClr) | evt;
        ax_nxt.irq = |(ax_nxt.irqSt & ax_nxt.irqMask);

        ax_nxt.rdData = 32'h0000_0000;
        if (regRd)
        begin
            case (regAddr)
                `AMSM_ADDR_CTRL:
                begin
                    ax_nxt.rdData[`AMSM_CTRL_PWR] = ax_r.powerEn;
                    ax_nxt.rdData[`AMSM_CTRL_ID_MSB:`AMSM_CTRL_ID_LSB] = ax_r.ownerId;
                    ax_nxt.rdData[`AMSM_CTRL_RDYMON] = ax_r.readyMonEn;
                    ax_nxt.rdData[`AMSM_CTRL_INPOS] = ax_r.inPosEn;
                end
                `AMSM_ADDR_EXEC:
                    ax_nxt.rdData[5:0] = ax_r.exec;
                `AMSM_ADDR_POS:
                    ax_nxt.rdData = ax_r.posParam;
                `AMSM_ADDR_VEL:
                    ax_nxt.rdData = {15'h0000, ax_r.velNeg, ax_r.velParam};
                `AMSM_ADDR_HOMEPOS:
                    ax_nxt.rdData = ax_r.homePos;
                `AMSM_ADDR_HOMEOFS:
                    ax_nxt.rdData = ax_r.homeOffset;
                `AMSM_ADDR_STATUS:
                begin
                    ax_nxt.rdData[2:0] = ax_r.state;
                    ax_nxt.rdData[`AMSM_STAT_MECH] = ax_r.mechErr;
                    ax_nxt.rdData[`AMSM_STAT_DONE_LSB +: 6] = ax_r.done;
                    ax_nxt.rdData[`AMSM_STAT_ERR_LSB +: 6] = ax_r.err;
                    ax_nxt.rdData[`AMSM_STAT_READY] = ax_r.sync2[0];
                    ax_nxt.rdData[`AMSM_STAT_INPOS] = ax_r.sync2[1];
                end
                `AMSM_ADDR_ACTPOS:
                    ax_nxt.rdData = mi.actPos;
                `AMSM_ADDR_IRQST:
                    ax_nxt.rdData[3:0] = ax_r.irqSt;
                `AMSM_ADDR_IRQMASK:
                    ax_nxt.rdData[3:0] = ax_r.irqMask;
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ax_r <= '0;
        end
        else
        begin
            ax_r <= ax_nxt;
        end
    end

    assign mi.tgtPos = ax_r.tgtPos;
    assign mi.cmdVel = ax_r.cmdVel;
    assign mi.posMode = ax_r.posMode;
    assign mi.dirNeg = ax_r.dirNeg;
    assign mi.run = ax_r.run;
    assign mi.loadPos = ax_r.loadPos;
    assign mi.loadVal = ax_r.homePos;
    assign regRdata = ax_r.rdData;
    assign stepPulse = mi.stepPulse;
    assign stepDir = mi.stepDir;
    assign driveOn = ax_r.powerEn;
    assign irq = ax_r.irq;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    a_stop_lock: assert property (ax_r.state == amsm_pkg::ST_STOPPING |=> !(ax_r.state inside
        {amsm_pkg::ST_DISCRETE, amsm_pkg::ST_CONTINUOUS, amsm_pkg::ST_HOMING}))
        else $error("motion started while stopping");
    a_stop_done: assert property (ax_r.state == amsm_pkg::ST_STOPPING && mi.velZero && !ax_r.fresh
        && rise == 6'h00 |=> ax_r.done[`AMSM_CMD_STOP])
        else $error("stop done missing at zero velocity");
    a_stop_hold: assert property (ax_r.state == amsm_pkg::ST_STOPPING && ax_r.exec[`AMSM_CMD_STOP]
        |=> ax_r.state != amsm_pkg::ST_STANDSTILL)
        else $error("left stopping with execute high");
    a_stop_release: assert property (ax_r.state == amsm_pkg::ST_STOPPING && ax_r.done[`AMSM_CMD_STOP]
        && !ax_r.exec[`AMSM_CMD_STOP] && !regWr |=> ax_r.state == amsm_pkg::ST_STANDSTILL)
        else $error("stopping not released");
    a_home_entry: assert property (rise[`AMSM_CMD_HOME] && !rise[`AMSM_CMD_STOP] && !rise[`AMSM_CMD_HALT]
        && ax_r.state != amsm_pkg::ST_STANDSTILL |=> ax_r.err[`AMSM_CMD_HOME]
        && (ax_r.state != amsm_pkg::ST_HOMING || $past(ax_r.state) == amsm_pkg::ST_HOMING))
        else $error("homing accepted outside standstill");
    a_reject_abs: assert property (rise == 6'h01 && ax_r.state == amsm_pkg::ST_STOPPING
        |=> ax_r.err[`AMSM_CMD_ABS] ##1 ax_r.irqSt[`AMSM_IRQ_REJECT] || irqClr[`AMSM_IRQ_REJECT])
        else $error("rejected move not flagged");
    a_drive_ready: assert property (ax_r.readyMonEn && !ax_r.sync2[0] && ax_r.state == amsm_pkg::ST_STANDSTILL
        |=> !(ax_r.state inside {amsm_pkg::ST_DISCRETE, amsm_pkg::ST_CONTINUOUS, amsm_pkg::ST_HOMING}))
        else $error("motion without drive ready");
    a_inpos_bound: assert property (ax_r.inPosArm |-> ax_r.inPosCnt < INPOS_CYCLES)
        else $error("in-position counter overran");
    a_rel_target: assert property (rise == 6'h02 && moveOk && !(regWr && regAddr == `AMSM_ADDR_CTRL)
        |=> ax_r.tgtPos == $past(relSum) && ax_r.posMode)
        else $error("relative target wrong");
    a_halt_end: assert property (ax_r.state == amsm_pkg::ST_DISCRETE && !ax_r.fresh && rise == 6'h00
        && ax_r.activeCmd == 3'(`AMSM_CMD_HALT) && mi.velZero && !regWr
        |=> ax_r.state == amsm_pkg::ST_STANDSTILL && ax_r.done[`AMSM_CMD_HALT])
        else $error("halt did not finish");
    a_power_clash: assert property (ctrlClash |=> ax_r.state == amsm_pkg::ST_ERRORSTOP ##1
        ax_r.state inside {amsm_pkg::ST_ERRORSTOP, amsm_pkg::ST_DISABLED})
        else $error("second power owner not trapped");
endmodule

/* File: testbench/amsm_servo_drive.sv */
// Behavioural servo drive on the step and direction pins
`timescale 1ns/1ps
module amsm_servo_drive (
    input wire logic core_clk,
    input wire logic driveOn,
    input wire logic stepPulse,
    input wire logic stepDir,
    output logic driveReady = 1'b0,
    output logic inPosition = 1'b0,
    output logic homeRef = 1'b0
);
    logic [31:0] pos = 32'h0000_0000;
    logic [7:0] idle = 8'h00;
    // Ready follows enable one clock later, so a drive just switched off still looks usable for one cycle
    always @(posedge core_clk)
    begin
        driveReady <= driveOn;
        if (stepPulse)
            pos <= stepDir ? pos - 32'h0000_0001 : pos + 32'h0000_0001;
        if (stepPulse)
            idle <= 8'h00;
        else if (idle != 8'hFF)
            idle <= idle + 8'h01;
        inPosition <= idle > 8'h08;
        homeRef <= pos[31];
    end
endmodule

/* File: testbench/amsm_tb.sv */
// Self-checking bench for the axis sequencer
`timescale 1ns/1ps
`include "amsm_params.svh"
module tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic driveReady, inPosition, homeRef, stepPulse, stepDir, driveOn, irq;
    int failures = 0;
    int checkCount = 0;
    amsm_axis_ctrl #(.INPOS_CYCLES(32'h0000_00C8)) dut (.core_clk(core_clk), .nrst(nrst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .driveReady(driveReady), .inPosition(inPosition),
        .homeRef(homeRef), .stepPulse(stepPulse), .stepDir(stepDir), .driveOn(driveOn), .irq(irq));
    amsm_servo_drive drv (.core_clk(core_clk), .driveOn(driveOn), .stepPulse(stepPulse),
        .stepDir(stepDir), .driveReady(driveReady), .inPosition(inPosition), .homeRef(homeRef));
    initial forever #2 core_clk = ~core_clk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Two idle edges after each write let the command edge land
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic poll(input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        for (int i = 0; i < 1000; i++)
        begin
            rd(`AMSM_ADDR_STATUS, v);
            if ((v & m) === e)
                break;
        end
        chk(v & m, e);
        if ((v & m) !== e)
            wrap_up();
    endtask
    task automatic t_power();
        wr(`AMSM_ADDR_CTRL, 32'h0000_0011);
        poll(32'h0000_0007, 32'h0000_0001);
        chk(32'(driveOn), 32'h0000_0001);
    endtask
    task automatic t_stop();
        logic [31:0] v;
        wr(`AMSM_ADDR_VEL, 32'h0000_0040);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0004);
        poll(32'h0000_0007, 32'h0000_0003);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0014);
        poll(32'h0000_0007, 32'h0000_0005);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0015);
        rd(`AMSM_ADDR_STATUS, v);
        chk(32'(v[16]), 32'h0000_0001);
        poll(32'h0000_1007, 32'h0000_1005);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0000);
        poll(32'h0000_0007, 32'h0000_0001);
    endtask
    task automatic t_move();
        logic [31:0] v;
        wr(`AMSM_ADDR_POS, 32'h0000_0010);
        wr(`AMSM_ADDR_VEL, 32'h0000_8000);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0001);
        poll(32'h0000_0107, 32'h0000_0101);
        chk(drv.pos, 32'h0000_0010);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0000);
        wr(`AMSM_ADDR_POS, 32'hFFFF_FFF8);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0002);
        poll(32'h0000_0207, 32'h0000_0201);
        rd(`AMSM_ADDR_ACTPOS, v);
        chk(v, 32'h0000_0008);
        chk(drv.pos, 32'h0000_0008);
        wr(`AMSM_ADDR_HOMEPOS, 32'h0000_0100);
        wr(`AMSM_ADDR_HOMEOFS, 32'hFFFF_FFF0);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0008);
        poll(32'h0000_0807, 32'h0000_0801);
        rd(`AMSM_ADDR_ACTPOS, v);
        chk(v, 32'h0000_0100);
        wr(`AMSM_ADDR_VEL, 32'h0000_0040);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0004);
        poll(32'h0000_0007, 32'h0000_0003);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0024);
        poll(32'h0000_2007, 32'h0000_2001);
        wr(`AMSM_ADDR_EXEC, 32'h0000_0000);
    endtask
    task automatic t_owner();
        wr(`AMSM_ADDR_IRQMASK, 32'h0000_0008);
        wr(`AMSM_ADDR_CTRL, 32'h0000_0021);
        poll(32'h0000_0007, 32'h0000_0006);
        chk(32'(irq), 32'h0000_0001);
        wr(`AMSM_ADDR_IRQST, 32'h0000_0008);
        chk(32'(irq), 32'h0000_0000);
        wr(`AMSM_ADDR_CTRL, 32'h0000_0000);
        poll(32'h0000_0007, 32'h0000_0000);
        chk(32'(driveOn), 32'h0000_0000);
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        t_power();
        t_stop();
        t_move();
        t_owner();
        wrap_up();
    end
endmodule
